/* File: pkg/fam_pkg.sv */
// Constants, commands and carriers for the flash array map
package fam_pkg;
	localparam int FAM_ADDR_W = 24;
	localparam int FAM_MAIN_AW = 20;
	localparam int FAM_MAIN_BYTES = 1048576;
	localparam int FAM_BLOCKS = 16;
	localparam int FAM_SECTORS = 256;
	localparam int FAM_PAGES = 4096;
	localparam int FAM_PAGE_LSB = 8;
	localparam int FAM_SECT_LSB = 12;
	localparam int FAM_BLK_LSB = 16;
	localparam int FAM_SEC_COUNT = 3;
	localparam int FAM_SEC_OFS_W = 9;
	localparam int FAM_SEC_AW = 11;
	localparam int FAM_SEC_BYTES = 1536;
	localparam int FAM_SEC_IDX_LSB = 12;
	localparam logic [7:0] FAM_ERASED = 8'hFF;
	localparam logic [3:0] FAM_MAIN_HI_ZERO = 4'h0;
	localparam logic [9:0] FAM_SEC_HI_ZERO = 10'h000;
	localparam logic [2:0] FAM_SEC_GAP_ZERO = 3'h0;
	localparam logic [1:0] FAM_SEC_PARAM_IDX = 2'h0;
	localparam logic [15:0] FAM_PARAM_HI_ZERO = 16'h0000;
	localparam logic [19:0] FAM_CHIP_LAST = 20'hFFFFF;
	localparam logic [11:0] FAM_SECT_ZERO = 12'h000;
	localparam logic [11:0] FAM_SECT_ONES = 12'hFFF;
	localparam logic [15:0] FAM_BLK_ZERO = 16'h0000;
	localparam logic [15:0] FAM_BLK_ONES = 16'hFFFF;
	localparam logic [8:0] FAM_SEC_ZERO = 9'h000;
	localparam logic [8:0] FAM_SEC_ONES = 9'h1FF;
	// Parameter space layout
	localparam logic [7:0] FAM_PS_HDR = 8'h00;
	localparam logic [7:0] FAM_PS_HDR_RSV = 8'h20;
	localparam logic [7:0] FAM_PS_TABLE = 8'h30;
	localparam logic [7:0] FAM_PS_END = 8'h7B;
	localparam logic [7:0] FAM_PS_RSV = 8'h7C;
	localparam logic [7:0] FAM_PS_SIG_S = 8'h53;
	localparam logic [7:0] FAM_PS_SIG_F = 8'h46;
	localparam logic [7:0] FAM_PS_SIG_D = 8'h44;
	localparam logic [7:0] FAM_PS_SIG_P = 8'h50;
	localparam logic [7:0] FAM_PS_MINOR = 8'h08;
	localparam logic [7:0] FAM_PS_MAJOR = 8'h01;
	localparam logic [7:0] FAM_PS_NHDR = 8'h01;
	localparam logic [7:0] FAM_PS_PROTO = 8'hFF;
	localparam logic [7:0] FAM_PS_ID_LSB = 8'h00;
	localparam logic [7:0] FAM_PS_TBL_MINOR = 8'h07;
	localparam logic [7:0] FAM_PS_TBL_MAJOR = 8'h01;
	localparam logic [7:0] FAM_PS_TBL_LEN = 8'h10;
	localparam logic [7:0] FAM_PS_TBL_PTR = 8'h30;
	localparam logic [7:0] FAM_PS_ZERO = 8'h00;
	localparam logic [7:0] FAM_PS_ID_MSB = 8'hFF;
	localparam logic [7:0] FAM_PS_H1_ID = 8'hA5; // Arbitrary value
	localparam logic [7:0] FAM_PS_H1_LEN = 8'h03;
	localparam logic [7:0] FAM_PS_H1_PTR = 8'h70;
	localparam logic [7:0] FAM_PS_BT0 = 8'hE5;
	localparam logic [7:0] FAM_PS_BT1 = 8'h20;
	localparam logic [7:0] FAM_PS_BT2 = 8'hF1;

	typedef enum logic [3:0] {
		FAM_OP_READ,
		FAM_OP_PROG,
		FAM_OP_ERASE_SECT,
		FAM_OP_ERASE_BLK,
		FAM_OP_ERASE_CHIP,
		FAM_OP_SEC_READ,
		FAM_OP_SEC_PROG,
		FAM_OP_SEC_ERASE,
		FAM_OP_SEC_LOCK,
		FAM_OP_PARAM_READ
	} fam_op_t;

	typedef struct packed {
		logic valid;
		fam_op_t op;
		logic [23:0] addr;
		logic [7:0] data;
	} fam_req_t;

	typedef struct packed {
		logic ack;
		logic err;
		logic [7:0] rdata;
	} fam_rsp_t;
endpackage

/* File: src/fam_flash_map.sv */
// Address map, content model and parameter space of the serial flash
`timescale 1ns/1ps
`default_nettype none
module fam_flash_map import fam_pkg::*; (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire fam_req_t req,
	output fam_rsp_t rsp,
	output logic busy,
	output logic [2:0] lock_status
);
	typedef enum logic [1:0] {FAM_ST_IDLE, FAM_ST_ERASE_MAIN, FAM_ST_ERASE_SEC} fam_state_t;

	logic [7:0] main_mem [0:FAM_MAIN_BYTES-1];
	logic [7:0] sec_mem [0:FAM_SEC_BYTES-1];
	fam_state_t state;
	fam_state_t next_state;
	logic [19:0] erase_ptr;
	logic [19:0] erase_last;
	logic [19:0] next_erase_ptr;
	logic [19:0] next_erase_last;

	// Parameter space contents
	function automatic logic [7:0] fam_param_byte(input logic [7:0] a);
		logic [7:0] b;
		b = FAM_ERASED;
		case (a)
			8'h00: b = FAM_PS_SIG_S;
			8'h01: b = FAM_PS_SIG_F;
			8'h02: b = FAM_PS_SIG_D;
			8'h03: b = FAM_PS_SIG_P;
			8'h04: b = FAM_PS_MINOR;
			8'h05: b = FAM_PS_MAJOR;
			8'h06: b = FAM_PS_NHDR;
			8'h07: b = FAM_PS_PROTO;
			8'h08: b = FAM_PS_ID_LSB;
			8'h09: b = FAM_PS_TBL_MINOR;
			8'h0A: b = FAM_PS_TBL_MAJOR;
			8'h0B: b = FAM_PS_TBL_LEN;
			8'h0C: b = FAM_PS_TBL_PTR;
			8'h0D: b = FAM_PS_ZERO;
			8'h0E: b = FAM_PS_ZERO;
			8'h0F: b = FAM_PS_ID_MSB;
			8'h10: b = FAM_PS_H1_ID;
			8'h11: b = FAM_PS_ZERO;
			8'h12: b = FAM_PS_TBL_MAJOR;
			8'h13: b = FAM_PS_H1_LEN;
			8'h14: b = FAM_PS_H1_PTR;
			8'h15: b = FAM_PS_ZERO;
			8'h16: b = FAM_PS_ZERO;
			8'h30: b = FAM_PS_BT0;
			8'h31: b = FAM_PS_BT1;
			8'h32: b = FAM_PS_BT2;
			default: b = FAM_ERASED;
		endcase
		return b;
	endfunction

	// Address decode
	wire logic [19:0] main_ofs = req.addr[FAM_MAIN_AW-1:0];
	wire logic in_main = req.addr[23:20] == FAM_MAIN_HI_ZERO;
	wire logic [7:0] sect_idx = req.addr[19:FAM_SECT_LSB];
	wire logic [3:0] blk_idx = req.addr[19:FAM_BLK_LSB];
	wire logic [1:0] sec_sel = req.addr[13:FAM_SEC_IDX_LSB];
	wire logic [1:0] sec_num = sec_sel - 2'd1;
	wire logic [8:0] sec_ofs = req.addr[FAM_SEC_OFS_W-1:0];
	wire logic sec_in_range = (req.addr[23:14] == FAM_SEC_HI_ZERO) && (req.addr[11:9] == FAM_SEC_GAP_ZERO);
	wire logic sec_is_param = sec_sel == FAM_SEC_PARAM_IDX;
	wire logic sec_ok = sec_in_range && !sec_is_param;
	wire logic sec_locked = lock_status[sec_num];
	wire logic [10:0] sec_addr = {sec_num, sec_ofs};
	wire logic param_in_range = req.addr[23:8] == FAM_PARAM_HI_ZERO;
	wire logic [7:0] param_byte = param_in_range ? fam_param_byte(req.addr[7:0]) : FAM_ERASED;

	// Request legality
	logic op_ok;
	always_comb begin
		case (req.op)
			FAM_OP_READ, FAM_OP_PROG: op_ok = in_main;
			FAM_OP_ERASE_SECT, FAM_OP_ERASE_BLK, FAM_OP_ERASE_CHIP: op_ok = in_main;
			FAM_OP_SEC_READ: op_ok = sec_ok;
			FAM_OP_SEC_PROG, FAM_OP_SEC_ERASE: op_ok = sec_ok && !sec_locked;
			FAM_OP_SEC_LOCK: op_ok = sec_ok;
			FAM_OP_PARAM_READ: op_ok = 1'b1;
			default: op_ok = 1'b0;
		endcase
	end

	wire logic take = req.valid;
	wire logic idle = state == FAM_ST_IDLE;
	wire logic do_op = take && idle && op_ok;
	wire logic do_prog_main = do_op && req.op == FAM_OP_PROG;
	wire logic do_prog_sec = do_op && req.op == FAM_OP_SEC_PROG;
	wire logic do_lock = do_op && req.op == FAM_OP_SEC_LOCK;
	wire logic do_er_sect = do_op && req.op == FAM_OP_ERASE_SECT;
	wire logic do_er_blk = do_op && req.op == FAM_OP_ERASE_BLK;
	wire logic do_er_chip = do_op && req.op == FAM_OP_ERASE_CHIP;
	wire logic do_er_sec = do_op && req.op == FAM_OP_SEC_ERASE;
	wire logic erase_main = state == FAM_ST_ERASE_MAIN;
	wire logic erase_sec = state == FAM_ST_ERASE_SEC;
	wire logic erase_done = erase_ptr == erase_last;
	wire logic [7:0] main_rd = main_mem[main_ofs];
	wire logic [7:0] sec_rd = sec_mem[sec_addr];

	// Read data selection
	logic [7:0] next_rdata;
	always_comb begin
		case (req.op)
			FAM_OP_READ: next_rdata = main_rd;
			FAM_OP_SEC_READ: next_rdata = sec_rd;
			FAM_OP_PARAM_READ: next_rdata = param_byte;
			default: next_rdata = FAM_ERASED;
		endcase
	end

	// Erase sequencing
	always_comb begin
		next_state = state;
		next_erase_ptr = erase_ptr;
		next_erase_last = erase_last;
		case (state)
			FAM_ST_IDLE: begin
				if (do_er_sect) begin
					next_state = FAM_ST_ERASE_MAIN;
					next_erase_ptr = {sect_idx, FAM_SECT_ZERO};
					next_erase_last = {sect_idx, FAM_SECT_ONES};
				end else if (do_er_blk) begin
					next_state = FAM_ST_ERASE_MAIN;
					next_erase_ptr = {blk_idx, FAM_BLK_ZERO};
					next_erase_last = {blk_idx, FAM_BLK_ONES};
				end else if (do_er_chip) begin
					next_state = FAM_ST_ERASE_MAIN;
					next_erase_ptr = '0;
					next_erase_last = FAM_CHIP_LAST;
				end else if (do_er_sec) begin
					next_state = FAM_ST_ERASE_SEC;
					next_erase_ptr = {9'h000, sec_num, FAM_SEC_ZERO};
					next_erase_last = {9'h000, sec_num, FAM_SEC_ONES};
				end
			end
			FAM_ST_ERASE_MAIN, FAM_ST_ERASE_SEC: begin
				if (erase_done) begin
					next_state = FAM_ST_IDLE;
				end else begin
					next_erase_ptr = erase_ptr + 20'd1;
				end
			end
			default: next_state = FAM_ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state <= FAM_ST_IDLE;
			erase_ptr <= '0;
			erase_last <= '0;
		end else begin
			state <= next_state;
			erase_ptr <= next_erase_ptr;
			erase_last <= next_erase_last;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			rsp <= '0;
			busy <= 1'b0;
			lock_status <= '0;
		end else begin
			rsp.ack <= take;
			rsp.err <= take && !(idle && op_ok);
			rsp.rdata <= do_op ? next_rdata : FAM_ERASED;
			busy <= next_state != FAM_ST_IDLE;
			if (do_lock) begin
				lock_status[sec_num] <= 1'b1;
			end
		end
	end

	// Array contents
	always_ff @(posedge sys_clk) begin
		if (erase_main) begin
			main_mem[erase_ptr] <= FAM_ERASED;
		end else if (do_prog_main) begin
			main_mem[main_ofs] <= main_rd & req.data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (erase_sec) begin
			sec_mem[erase_ptr[10:0]] <= FAM_ERASED;
		end else if (do_prog_sec) begin
			sec_mem[sec_addr] <= sec_rd & req.data;
		end
	end

	// Checks
	logic chk_prog;
	logic [19:0] chk_addr;
	logic [7:0] chk_val;
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			chk_prog <= 1'b0;
			chk_addr <= '0;
			chk_val <= '0;
		end else begin
			chk_prog <= do_prog_main;
			chk_addr <= main_ofs;
			chk_val <= main_rd & req.data;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	prog_clears_bits_a: assert property (chk_prog |-> main_mem[chk_addr] == chk_val) else $error("program set a bit");
	sig_bytes_a: assert property (do_op && req.op == FAM_OP_PARAM_READ && req.addr == 24'h000000 |=> rsp.rdata == 8'h53)
		else $error("signature byte wrong");
	hdr_revision_a: assert property (do_op && req.op == FAM_OP_PARAM_READ && req.addr == 24'h000004 |=> rsp.rdata == 8'h08)
		else $error("minor revision wrong");
	hdr_count_a: assert property (do_op && req.op == FAM_OP_PARAM_READ && req.addr == 24'h000006 |=> rsp.rdata == 8'h01)
		else $error("header count wrong");
	reserved_ones_a: assert property (do_op && req.op == FAM_OP_PARAM_READ && param_in_range && req.addr[7:0] >= 8'h7C
		|=> rsp.rdata == 8'hFF) else $error("reserved byte not FFh");
	sec_zero_ro_a: assert property (take && (req.op == FAM_OP_SEC_PROG || req.op == FAM_OP_SEC_ERASE) && sec_is_param
		|=> rsp.ack && rsp.err) else $error("security zero write taken");
	lock_blocks_a: assert property (take && req.op == FAM_OP_SEC_PROG && sec_ok && sec_locked |=> rsp.err)
		else $error("locked register written");
	sect_erase_span_a: assert property (do_er_sect |=> erase_main && erase_ptr[11:0] == 12'h000
		&& erase_last[11:0] == 12'hFFF && erase_ptr[19:12] == $past(sect_idx)) else $error("sector range wrong");
	busy_erase_a: assert property (do_er_sect |=> busy [*8]) else $error("busy dropped early");
	lock_sticks_a: assert property ($past(lock_status[0]) |-> lock_status[0]) else $error("lock bit cleared");

	chip_erase_c: cover property (do_er_chip);
	param_read_c: cover property (do_op && req.op == FAM_OP_PARAM_READ);
	sec_lock_c: cover property (do_lock);
	main_prog_c: cover property (do_prog_main);
endmodule
`default_nettype wire

/* File: tb/fam_host_model.sv */
// Host model issuing one flash request at a time
`timescale 1ns/1ps
`default_nettype none
module fam_host_model import fam_pkg::*; (
	input wire logic sys_clk,
	output var fam_req_t req,
	input wire fam_rsp_t rsp
);
	initial req = '{valid: 1'b0, op: FAM_OP_READ, addr: 24'h000000, data: 8'h00};
	// Held to the answer edge, lines scrambled after release
	task automatic xfer(input fam_op_t o, input logic [23:0] a, input logic [7:0] d, output fam_rsp_t r);
		@(posedge sys_clk) #1;
		req = '{valid: 1'b1, op: o, addr: a, data: d};
		@(posedge sys_clk) #1;
		r = rsp;
		req = '{valid: 1'b0, op: o, addr: ~a, data: ~d};
	endtask
endmodule
`default_nettype wire

/* File: tb/tb_fam_flash_map.sv */
// Self-checking bench for the flash array map
`timescale 1ns/1ps
`default_nettype none
module tb_fam_flash_map import fam_pkg::*;;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	fam_req_t req;
	fam_rsp_t rsp;
	fam_rsp_t r;
	logic busy;
	logic [2:0] lock_status;
	int n_mismatch = 0;
	int checked = 0;
	int seed = 63;
	logic [7:0] mem [int];
	fam_flash_map i_fam_flash_map (.sys_clk(sys_clk), .reset_n(reset_n), .req(req), .rsp(rsp), .busy(busy),
		.lock_status(lock_status));
	fam_host_model i_fam_host_model (.sys_clk(sys_clk), .req(req), .rsp(rsp));
	initial begin
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		if (n_mismatch == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Request plus check of answer
	task automatic issue(input fam_op_t o, input logic [23:0] a, input logic [7:0] d, input logic e,
		input logic [7:0] rd);
		i_fam_host_model.xfer(o, a, d, r);
		check("ack", r.ack, 1'b1);
		check("err", r.err, e);
		check("rdata", r.rdata, rd);
	endtask
	// Counts edges until busy falls
	task automatic wait_idle(input int n);
		int k = 0;
		while (busy === 1'b1 && k < n + 10) begin
			@(posedge sys_clk) #1;
			k++;
		end
		check("busy span", k, n);
	endtask
	function automatic logic [7:0] pexp(input int i);
		logic [7:0] hdr [24] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h08, 8'h01, 8'h01, 8'hFF, 8'h00, 8'h07, 8'h01,
			8'h10, 8'h30, 8'h00, 8'h00, 8'hFF, FAM_PS_H1_ID, 8'h00, 8'h01, 8'h03, 8'h70, 8'h00, 8'h00, 8'hFF};
		if (i < 24) return hdr[i];
		if (i == 48) return 8'hE5;
		if (i == 49) return 8'h20;
		if (i == 50) return 8'hF1;
		return 8'hFF;
	endfunction
	initial begin
		#(100000 * 40);
		n_mismatch++;
		conclude();
	end
	initial begin
		logic [23:0] a;
		logic [7:0] d;
		int b;
		repeat (20) @(posedge sys_clk);
		#1 reset_n = 1'b1;
		check("ack rst", rsp.ack, 1'b0);
		check("rdata rst", rsp.rdata, 8'h00);
		check("lock rst", lock_status, 3'h0);
		for (int i = 0; i < 257; i++) begin
			issue(FAM_OP_PARAM_READ, 24'(i), 8'h00, 1'b0, pexp(i));
		end
		b = {$random(seed)} % 256;
		issue(FAM_OP_ERASE_SECT, 24'(b << 12), 8'h00, 1'b0, 8'hFF);
		check("busy", busy, 1'b1);
		issue(FAM_OP_PARAM_READ, 24'h000000, 8'h00, 1'b1, 8'hFF);
		wait_idle(4094);
		for (int j = 0; j < 4096; j++) mem[(b << 12) + j] = 8'hFF;
		for (int j = 0; j < 8; j++) begin
			a = 24'((b << 12) | ({$random(seed)} % 4096));
			d = 8'($random(seed));
			issue(FAM_OP_PROG, a, d, 1'b0, 8'hFF);
			mem[a] = mem[a] & d;
			issue(FAM_OP_READ, a, 8'h00, 1'b0, mem[a]);
		end
		issue(FAM_OP_READ, 24'((b << 12) | 12'hFFF), 8'h00, 1'b0, mem[(b << 12) | 12'hFFF]);
		issue(FAM_OP_ERASE_BLK, 24'((b >> 4) << 16), 8'h00, 1'b0, 8'hFF);
		wait_idle(65536);
		issue(FAM_OP_READ, a, 8'h00, 1'b0, 8'hFF);
		issue(FAM_OP_READ, 24'h100000, 8'h00, 1'b1, 8'hFF);
		issue(fam_op_t'(4'hF), 24'h000000, 8'h00, 1'b1, 8'hFF);
		issue(FAM_OP_SEC_PROG, 24'h000010, 8'h00, 1'b1, 8'hFF);
		issue(FAM_OP_SEC_ERASE, 24'h000000, 8'h00, 1'b1, 8'hFF);
		issue(FAM_OP_SEC_READ, 24'h001200, 8'h00, 1'b1, 8'hFF);
		for (int k = 1; k < 4; k++) begin
			issue(FAM_OP_SEC_ERASE, 24'(k << 12), 8'h00, 1'b0, 8'hFF);
			wait_idle(512);
			issue(FAM_OP_SEC_PROG, 24'((k << 12) | 511), 8'h5A ^ 8'(k), 1'b0, 8'hFF);
		end
		issue(FAM_OP_SEC_LOCK, 24'h002000, 8'h00, 1'b0, 8'hFF);
		check("lock", lock_status, 3'h2);
		issue(FAM_OP_SEC_PROG, 24'h0021FF, 8'h00, 1'b1, 8'hFF);
		issue(FAM_OP_SEC_ERASE, 24'h002000, 8'h00, 1'b1, 8'hFF);
		issue(FAM_OP_SEC_READ, 24'h0021FF, 8'h00, 1'b0, 8'h58);
		issue(FAM_OP_SEC_PROG, 24'h0011FF, 8'h0F, 1'b0, 8'hFF);
		issue(FAM_OP_SEC_READ, 24'h0011FF, 8'h00, 1'b0, 8'h0B);
		issue(FAM_OP_SEC_READ, 24'h0031FF, 8'h00, 1'b0, 8'h59);
		issue(FAM_OP_ERASE_CHIP, 24'h000000, 8'h00, 1'b0, 8'hFF);
		check("busy", busy, 1'b1);
		reset_n = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 reset_n = 1'b1;
		check("busy rst", busy, 1'b0);
		check("lock rst", lock_status, 3'h0);
		conclude();
	end
endmodule
`default_nettype wire
